// file: verilog/epi_port.sv
// External port: arbitration, bus cycles, packing and peripheral DMA handshake
//
// Contract
// - One bus: 32-bit address, 64-bit data
// - PM, DM, IO sources share the port
// - Full 32-bit word address space
// - Even word low lane, odd word high
// - One word per address; wide moves two
// - Fetch reads two words, drops 16 bits
// - Asynchronous, synchronous and burst access types
// - High address bits decode bank selects
// - Page-mode DRAM control outputs
// - Programmable wait states plus acknowledge
// - DMA packs 16, 32, 48, 64-bit words
// - Four DMA channels use the port
// - Two peripheral request inputs, matching grants
// - DMA runs beside core without intervention
// - Bank selects low; same timing in every mode
// - Low and high word read strobes
// - Low and high word write strobes
`timescale 1ns/1ps
`include "epi_map.svh"
module epi_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`EPI_SRC_NUM-1:0] req_valid,
  input wire epi_pkg::epi_req_type [`EPI_SRC_NUM-1:0] req,
  output logic [`EPI_SRC_NUM-1:0] req_done,
  output logic [`EPI_DATA_W-1:0] rd_data,
  input wire epi_pkg::epi_mode_type access_mode,
  input wire logic [`EPI_WAIT_W-1:0] wait_states,
  input wire logic ack_enable,
  input wire logic [4:0] bank_size_log2,
  output logic [`EPI_ADDR_W-1:0] ext_addr,
  output logic [`EPI_DATA_W-1:0] ext_data_out,
  output logic ext_data_oe,
  input wire logic [`EPI_DATA_W-1:0] ext_data_in,
  output logic [`EPI_BANKS-1:0] bank_select_n,
  output logic read_low_word_strobe_n,
  output logic read_high_word_strobe_n,
  output logic write_low_word_strobe_n,
  output logic write_high_word_strobe_n,
  output logic page_cross,
  output logic burst_out,
  output logic fetch_n,
  input wire logic ack_in,
  input wire logic [`EPI_PERIPH_CH-1:0] dma_request_in,
  output logic [`EPI_PERIPH_CH-1:0] dma_grant_out,
  output logic [`EPI_PERIPH_CH-1:0] peripheral_pending
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_TURN} epi_state_type;

  epi_state_type state_r;
  logic ack_meta_r;
  logic ack_s_r;
  logic [`EPI_PERIPH_CH-1:0] dreq_meta_r;
  logic [`EPI_PERIPH_CH-1:0] dreq_s_r;
  logic [1:0] src_r;
  epi_pkg::epi_req_type cur_r;
  epi_pkg::epi_pack_type pack_r;
  logic [1:0] beat_r;
  logic [1:0] beat_last_r;
  logic [`EPI_WAIT_W-1:0] wait_r;
  logic [`EPI_DATA_W-1:0] rbuf_r;
  logic [`EPI_ADDR_W-1:0] last_addr_r;
  logic last_valid_r;
  logic [1:0] pick;
  logic any_req;
  epi_pkg::epi_pack_type pick_pack;
  logic [1:0] pick_last;
  logic [`EPI_ADDR_W-1:0] beat_addr;
  logic beat_done;
  logic last_beat;
  logic wide_beat;
  logic [`EPI_LANE_W-1:0] lane_in;
  logic [`EPI_DATA_W-1:0] beat_wdata;
  logic [`EPI_ADDR_W-1:0] bank_hi;
  logic [`EPI_SRC_NUM-1:0] vld;
  logic load;
  epi_pkg::epi_req_type ld_req;
  epi_pkg::epi_pack_type ld_pack;
  logic [1:0] ld_beat;
  logic [`EPI_ADDR_W-1:0] ld_addr;

  // Two-stage synchronisers for the acknowledge and DMA request pins
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ack_meta_r <= 1'b0;
      ack_s_r <= 1'b0;
      dreq_meta_r <= '0;
      dreq_s_r <= '0;
    end
    else
    begin
      ack_meta_r <= ack_in;
      ack_s_r <= ack_meta_r;
      dreq_meta_r <= dma_request_in;
      dreq_s_r <= dreq_meta_r;
    end
  end

  // Fixed priority: PM, then DM, then IO, then DMA
  always_comb
  begin
    pick = 2'(`EPI_SRC_DMA);
    vld = req_valid & ~req_done;
    any_req = |vld;
    for (int i = `EPI_SRC_NUM - 1; i >= 0; i--)
    begin
      if (vld[i])
        pick = 2'(i);
    end
  end

  // Effective word format per source
  always_comb
  begin
    if (pick == 2'(`EPI_SRC_DMA))
      pick_pack = req[pick].pack;
    else if (req[pick].fetch)
      pick_pack = epi_pkg::EPI_P48;
    else if (req[pick].wide)
      pick_pack = epi_pkg::EPI_P64;
    else
      pick_pack = epi_pkg::EPI_P32;
    unique case (pick_pack)
      epi_pkg::EPI_P16: pick_last = 2'd3;
      epi_pkg::EPI_P32: pick_last = (pick == 2'(`EPI_SRC_DMA)) ? 2'd1 : 2'd0;
      epi_pkg::EPI_P48: pick_last = 2'd0;
      epi_pkg::EPI_P64: pick_last = 2'd0;
    endcase
  end

  // Fields of the beat about to be launched
  always_comb
  begin
    load = (state_r == ST_IDLE && any_req) || (state_r == ST_TURN && !last_beat);
    if (state_r == ST_IDLE)
    begin
      ld_req = req[pick];
      ld_pack = pick_pack;
      ld_beat = 2'h0;
    end
    else
    begin
      ld_req = cur_r;
      ld_pack = pack_r;
      ld_beat = beat_r + 2'd1;
    end
  end

  assign ld_addr = ld_req.addr + `EPI_ADDR_W'(ld_beat);
  assign wide_beat = (ld_pack == epi_pkg::EPI_P48) || (ld_pack == epi_pkg::EPI_P64);
  assign beat_addr = cur_r.addr + `EPI_ADDR_W'(beat_r);
  assign beat_done = (state_r == ST_ACCESS) && (wait_r == '0) && (ack_s_r || !ack_enable);
  assign last_beat = (beat_r == beat_last_r);
  assign lane_in = beat_addr[0] ? ext_data_in[63:32] : ext_data_in[31:0];
  assign bank_hi = ld_addr >> bank_size_log2;

  // Write data for the coming beat
  always_comb
  begin
    unique case (ld_pack)
      epi_pkg::EPI_P16: beat_wdata = {2{16'h0000, ld_req.wdata[ld_beat*16 +: 16]}};
      epi_pkg::EPI_P32: beat_wdata = {2{ld_req.wdata[ld_beat[0]*32 +: 32]}};
      epi_pkg::EPI_P48: beat_wdata = {16'h0000, ld_req.wdata[47:0]};
      epi_pkg::EPI_P64: beat_wdata = ld_req.wdata;
    endcase
  end

  // Sequencer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      src_r <= 2'h0;
      cur_r <= '0;
      pack_r <= epi_pkg::EPI_P32;
      beat_r <= 2'h0;
      beat_last_r <= 2'h0;
      wait_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (any_req)
          begin
            state_r <= ST_ACCESS;
            src_r <= pick;
            cur_r <= req[pick];
            pack_r <= pick_pack;
            beat_r <= 2'h0;
            beat_last_r <= pick_last;
            wait_r <= wait_states;
          end
        end
        ST_ACCESS:
        begin
          if (wait_r != '0)
            wait_r <= wait_r - `EPI_WAIT_W'(1);
          else if (beat_done)
            state_r <= ST_TURN;
        end
        ST_TURN:
        begin
          if (!last_beat)
          begin
            state_r <= ST_ACCESS;
            beat_r <= beat_r + 2'd1;
            wait_r <= wait_states;
          end
          else
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin drivers, all from flip-flops
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ext_addr <= `EPI_RST_ADDR;
      ext_data_out <= `EPI_RST_DATA;
      ext_data_oe <= 1'b0;
      bank_select_n <= `EPI_RST_BANK_N;
      read_low_word_strobe_n <= 1'b1;
      read_high_word_strobe_n <= 1'b1;
      write_low_word_strobe_n <= 1'b1;
      write_high_word_strobe_n <= 1'b1;
      fetch_n <= 1'b1;
    end
    else if (load)
    begin
      ext_addr <= ld_addr;
      ext_data_oe <= ld_req.write;
      ext_data_out <= beat_wdata;
      fetch_n <= !ld_req.fetch;
      bank_select_n <= `EPI_RST_BANK_N;
      if (bank_hi < `EPI_ADDR_W'(`EPI_BANKS))
        bank_select_n[bank_hi[1:0]] <= 1'b0;
      read_low_word_strobe_n <= !(!ld_req.write && (wide_beat || !ld_addr[0]));
      read_high_word_strobe_n <= !(!ld_req.write && (wide_beat || ld_addr[0]));
      write_low_word_strobe_n <= !(ld_req.write && (wide_beat || !ld_addr[0]));
      write_high_word_strobe_n <= !(ld_req.write && (wide_beat || ld_addr[0]));
    end
    else if (beat_done)
    begin
      bank_select_n <= `EPI_RST_BANK_N;
      read_low_word_strobe_n <= 1'b1;
      read_high_word_strobe_n <= 1'b1;
      write_low_word_strobe_n <= 1'b1;
      write_high_word_strobe_n <= 1'b1;
      ext_data_oe <= 1'b0;
      fetch_n <= 1'b1;
    end
  end

  // Read data assembly
  always_ff @(posedge clock)
  begin
    if (rst)
      rbuf_r <= `EPI_RST_DATA;
    else if (state_r == ST_IDLE)
      rbuf_r <= `EPI_RST_DATA;
    else if (beat_done && !cur_r.write)
    begin
      unique case (pack_r)
        epi_pkg::EPI_P16: rbuf_r[beat_r*16 +: 16] <= lane_in[15:0];
        epi_pkg::EPI_P32: rbuf_r[beat_r[0]*32 +: 32] <= lane_in;
        epi_pkg::EPI_P48: rbuf_r <= {16'h0000, ext_data_in[47:0]};
        epi_pkg::EPI_P64: rbuf_r <= ext_data_in;
      endcase
    end
  end

  // Completion pulse and returned data
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      req_done <= '0;
      rd_data <= `EPI_RST_DATA;
    end
    else
    begin
      req_done <= '0;
      if (state_r == ST_TURN && last_beat)
      begin
        req_done[src_r] <= 1'b1;
        rd_data <= rbuf_r;
      end
    end
  end

  // Page and burst tracking
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      last_addr_r <= `EPI_RST_ADDR;
      last_valid_r <= 1'b0;
      page_cross <= 1'b0;
      burst_out <= 1'b0;
    end
    else if (load)
    begin
      page_cross <= !last_valid_r ||
        (ld_addr[31:`EPI_PAGE_LSB] != last_addr_r[31:`EPI_PAGE_LSB]);
      burst_out <= (access_mode == epi_pkg::EPI_BURST) && last_valid_r &&
        (ld_addr == last_addr_r + `EPI_ADDR_W'(1));
    end
    else if (beat_done)
    begin
      last_addr_r <= beat_addr;
      last_valid_r <= (access_mode != epi_pkg::EPI_ASYNC);
    end
  end

  // Peripheral request and grant for the first two DMA channels
  genvar g;
  generate
    for (g = 0; g < `EPI_PERIPH_CH; g++)
    begin : g_periph
      always_ff @(posedge clock)
      begin
        if (rst)
          dma_grant_out[g] <= 1'b0;
        else if (!dma_grant_out[g] && dreq_s_r[g])
          dma_grant_out[g] <= 1'b1;
        else if (state_r == ST_TURN && last_beat && src_r == 2'(`EPI_SRC_DMA) &&
                 cur_r.chan == 2'(g))
          dma_grant_out[g] <= 1'b0;
      end
      assign peripheral_pending[g] = dma_grant_out[g];
    end
  endgenerate
endmodule : epi_port

// file: include/epi_map.svh
// Constants for the external port interface
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH
`define EPI_ADDR_W 32
`define EPI_DATA_W 64
`define EPI_LANE_W 32
`define EPI_BANKS 4
`define EPI_SRC_NUM 4
`define EPI_SRC_PM 0
`define EPI_SRC_DM 1
`define EPI_SRC_IO 2
`define EPI_SRC_DMA 3
`define EPI_PERIPH_CH 2
`define EPI_WAIT_W 4
`define EPI_PAGE_LSB 9
`define EPI_FETCH_UNUSED 16
`define EPI_RST_ADDR 32'h0000_0000
`define EPI_RST_DATA 64'h0000_0000_0000_0000
`define EPI_RST_BANK_N 4'hF
`endif

// file: include/epi_pkg.sv
// Types shared by the external port interface
package epi_pkg;
  typedef enum logic [1:0] {EPI_ASYNC, EPI_SYNC, EPI_BURST} epi_mode_type;
  typedef enum logic [1:0] {EPI_P16, EPI_P32, EPI_P48, EPI_P64} epi_pack_type;
  typedef struct packed {
    logic write;
    logic fetch;
    logic wide;
    epi_pack_type pack;
    logic [1:0] chan;
    logic [31:0] addr;
    logic [63:0] wdata;
  } epi_req_type;
endpackage : epi_pkg

// file: verif/epi_port_props.sv
// Checker for the external port
`timescale 1ns/1ps
module epi_port_props (
  input logic clock,
  input logic rst,
  input logic [3:0] req_done,
  input logic ext_data_oe,
  input logic [3:0] bank_select_n,
  input logic read_low_word_strobe_n,
  input logic read_high_word_strobe_n,
  input logic write_low_word_strobe_n,
  input logic write_high_word_strobe_n,
  input logic [1:0] dma_grant_out,
  input logic [1:0] peripheral_pending
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  wire rd = !read_low_word_strobe_n || !read_high_word_strobe_n;
  wire wr = !write_low_word_strobe_n || !write_high_word_strobe_n;
  sequence s_grant;
    $rose(dma_grant_out[0]);
  endsequence
  sequence s_release;
    ##[1:60] !dma_grant_out[0];
  endsequence
  rw_excl_a: assert property (!(rd && wr))
    else $error("read and write strobes together");
  oe_write_a: assert property (wr |-> ext_data_oe)
    else $error("write strobe without data drive");
  bank_one_a: assert property ($onehot0(~bank_select_n))
    else $error("more than one bank selected");
  pend_grant_a: assert property (peripheral_pending == dma_grant_out)
    else $error("pending differs from grant");
  done_pulse_a: assert property (req_done != 4'h0 |=> req_done == 4'h0)
    else $error("done longer than one cycle");
  done_one_a: assert property ($onehot0(req_done))
    else $error("two sources done together");
  grant_rel_a: assert property (s_grant |-> s_release)
    else $error("grant held too long");
  rst_idle_a: assert property ($fell(rst) |-> bank_select_n == 4'hF && !rd && !wr)
    else $error("bus not idle after reset");
endmodule : epi_port_props

// file: verif/epi_mem_model.sv
// Memory model on the external bus
`timescale 1ns/1ps
module epi_mem_model (
  input logic clock,
  input logic [31:0] ext_addr,
  input logic [63:0] ext_data_out,
  input logic [3:0] strb_n,
  input logic [3:0] ack_dly,
  output logic [63:0] ext_data_in,
  output logic ack_in = 1'b0
);
  logic [31:0] mem [0:15];
  logic [63:0] last_r = 64'h0;
  logic [3:0] cnt_r = 4'h0;
  wire [3:0] a = {ext_addr[3:1], 1'b0};
  wire act = strb_n != 4'hF;
  assign ext_data_in = strb_n[1:0] != 2'h3 ? {mem[a + 4'h1], mem[a]} : ~last_r;
  always @(posedge clock)
  begin
    last_r <= ext_data_in;
    cnt_r <= act ? cnt_r + 4'h1 : 4'h0;
    ack_in <= act && cnt_r >= ack_dly;
    if (!strb_n[2]) mem[a] <= ext_data_out[31:0];
    if (!strb_n[3]) mem[a + 4'h1] <= ext_data_out[63:32];
  end
endmodule : epi_mem_model

// file: verif/tb_top.sv
// Bench for the external port
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0, rst = 1'b1, ack_enable = 1'b0, ext_data_oe, ack_in;
  logic page_cross, burst_out, fetch_n;
  logic [3:0] req_valid = 4'h0, wait_states = 4'h0, ack_dly = 4'h0, req_done, bank_select_n;
  logic [4:0] bank_size_log2 = 5'h02;
  logic [1:0] dma_request_in = 2'h0, dma_grant_out, peripheral_pending;
  logic [31:0] ext_addr;
  logic [63:0] rd_data, ext_data_out, ext_data_in;
  logic read_low_word_strobe_n, read_high_word_strobe_n;
  logic write_low_word_strobe_n, write_high_word_strobe_n;
  epi_pkg::epi_req_type [3:0] req = '0;
  epi_pkg::epi_mode_type access_mode = epi_pkg::EPI_ASYNC;
  logic [3:0] bank_seen, seen_done, strb_acc;
  logic [2:0] flag_acc;
  int error_cnt = 0, comparisons = 0, strb_cyc;
  wire [3:0] strb_n = {write_high_word_strobe_n, write_low_word_strobe_n,
    read_high_word_strobe_n, read_low_word_strobe_n};
  epi_port u_epi_port (.*);
  epi_mem_model u_epi_mem_model (.clock(clock), .ext_addr(ext_addr), .strb_n(strb_n),
    .ext_data_out(ext_data_out), .ack_dly(ack_dly), .ext_data_in(ext_data_in), .ack_in(ack_in));
  initial forever #12.5 clock = ~clock;
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_done(int s);
    int n;
    n = 0;
    seen_done = 4'h0;
    strb_acc = 4'hF;
    strb_cyc = 0;
    flag_acc = 3'h0;
    do
    begin
      @(posedge clock);
      n++;
      seen_done |= req_done;
      flag_acc |= {!fetch_n, burst_out, page_cross};
      if (strb_acc == 4'hF) bank_seen = bank_select_n;
      strb_acc &= strb_n;
      strb_cyc += int'(strb_n != 4'hF);
    end
    while (req_done[s] !== 1'b1 && n < 200);
    req_valid[s] <= 1'b0;
    check("done", req_done[s], 1'b1);
  endtask : wait_done
  task automatic xfer(int s, logic w, logic f, logic wd, logic [31:0] a, logic [63:0] d,
    logic [1:0] c = 2'h0, logic [3:0] also = 4'h0);
    @(posedge clock);
    req[s] <= '{w, f, wd, epi_pkg::EPI_P32, c, a, d};
    req_valid <= req_valid | also | (4'h1 << s);
    wait_done(s);
  endtask : xfer
  task automatic t_lanes();
    for (int m = 0; m < 3; m++)
    begin
      access_mode <= epi_pkg::epi_mode_type'(m);
      xfer(1, 1'b1, 1'b0, 1'b0, 32'h0000_0005, {32'h0, 32'hC500_0000 + m});
      if (m == 0) check("page", flag_acc[0], 1'b1);
      check("wr lanes", strb_acc, 4'h7);
      check("wr bank", bank_seen, 4'hD);
      xfer(1, 1'b0, 1'b0, 1'b0, 32'h0000_0005, 64'h0);
      check("rd lanes", strb_acc, 4'hD);
      check("rd data", rd_data[31:0], 32'hC500_0000 + m);
    end
    access_mode <= epi_pkg::EPI_ASYNC;
  endtask : t_lanes
  task automatic t_wide();
    xfer(1, 1'b1, 1'b0, 1'b1, 32'h0000_0002, 64'h1111_2222_3333_4444);
    check("wide lanes", strb_acc, 4'h3);
    check("wide bank", bank_seen, 4'hE);
    check("no fetch", flag_acc[2], 1'b0);
    xfer(0, 1'b0, 1'b1, 1'b0, 32'h0000_0002, 64'h0);
    check("fetch", rd_data, 64'h0000_2222_3333_4444);
    check("fetch lanes", strb_acc, 4'hC);
    check("fetch pin", flag_acc[2], 1'b1);
  endtask : t_wide
  task automatic t_prio();
    req[2] <= '{1'b0, 1'b0, 1'b0, epi_pkg::EPI_P32, 2'h0, 32'h0000_0002, 64'h0};
    xfer(0, 1'b0, 1'b0, 1'b0, 32'h0000_0003, 64'h0, 2'h0, 4'h4);
    check("io waits", seen_done[2], 1'b0);
    check("pm data", rd_data[31:0], 32'h1111_2222);
    wait_done(2);
    check("io data", rd_data[31:0], 32'h3333_4444);
  endtask : t_prio
  task automatic t_wait();
    access_mode <= epi_pkg::EPI_BURST;
    wait_states <= 4'h3;
    ack_enable <= 1'b1;
    ack_dly <= 4'h5;
    xfer(1, 1'b0, 1'b0, 1'b0, 32'h0000_0002, 64'h0);
    check("slow beat", strb_cyc > 6, 1'b1);
    check("slow data", rd_data[31:0], 32'h3333_4444);
  endtask : t_wait
  task automatic t_dma();
    int n;
    for (int c = 0; c < 2; c++)
    begin
      n = 0;
      dma_request_in <= 2'h1 << c;
      do
      begin
        @(posedge clock);
        n++;
      end
      while (dma_grant_out[c] !== 1'b1 && n < 50);
      dma_request_in <= 2'h0;
      check("grant", dma_grant_out, 2'h1 << c);
      xfer(3, 1'b1, 1'b0, 1'b0, 32'h0000_0008, 64'h0, 2'(c));
      check("burst", flag_acc[1], 1'b1);
    end
  endtask : t_dma
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    t_lanes();
    t_wide();
    t_prio();
    t_wait();
    t_dma();
    test_done();
  end
  initial
  begin
    #1000000;
    error_cnt++;
    test_done();
  end
endmodule : tb_top
bind epi_port epi_port_props u_epi_port_props (.*);
